// [core/timer_pwm_channel_pair.sv]
// Two-channel timer PWM generator with APB register access.
// Assumes one 200 MHz clock, APB master on same clock, pins synchronised here.
//
// The implementer's own choices: register access over APB and the address map.
`default_nettype none
`include "pwm_pair_map.svh"

// Overview of operation
// - Period is modulo value plus one prescaled timer clocks.
// - Pulse width equals channel compare value in prescaled clocks.
// - Unbuffered mode compares directly with the channel compare register.
// - Channel compare event raised, and request if enabled, when counter matches channel value.
// - Overflow event raised, and request if enabled, at end of each period.
// - Channel 0 buffered bit links channels, output on channel 0 pin.
// - At each overflow the linked output uses the pair written last.
// - Linked mode uses channel 0 control only; channel 1 pin released.
// - Mode field 0:1 unbuffered, 1:0 buffered.
// - Toggle-on-overflow set, action 1:0 clears, 1:1 sets on compare.
// - Toggle-on-overflow clear gives no overflow toggle; with action 1:0 zero duty.
// - Full-duty bit with toggle-on-overflow and action 1:x holds output active all period.
// - Overflow flag set at modulo match; request only when enabled.
// - Channel flag set on each compare; request when enabled.
// - In wait the counter keeps running; enabled requests still assert.
// - In stop the block halts keeping registers and counter.
// - Counter frozen while break is active.
// - During break flags clear only when break clear allow is one.
// - After modulo the counter restarts at zero next timer clock.
// - Divider select 0..6 gives bus clock divided 1..64; 7 external.
// - Flags clear by read with flag set then write zero.
// - Reset sets halt; counter clear bit clears counter, reads zero.
module timer_pwm_channel_pair
    import pwm_pair_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input  wire logic        CLK_SYS_I,
    input  wire logic        ARST_N_I,
    // APB slave
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [11:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    // External timer clock pin
    input  wire logic        EXT_TCLK_I,
    // Channel pins
    output logic             CHAN0_PIN_O,
    output logic             CHAN0_PIN_OE_O,
    output logic             CHAN1_PIN_O,
    output logic             CHAN1_PIN_OE_O,
    // Interrupt requests
    output logic             WRAP_IRQ_O,
    output logic             CHAN0_IRQ_O,
    output logic             CHAN1_IRQ_O
);

    // ************************************************************
    // Bus decode
    // ************************************************************
    wire acc      = PSEL_I & PENABLE_I;
    wire wr       = acc & PWRITE_I;
    wire rd       = acc & ~PWRITE_I;
    wire setup    = PSEL_I & ~PENABLE_I;
    wire rd_setup = setup & ~PWRITE_I;
    wire sel_tcs  = PADDR_I == `OFF_TIMER_CTL_STAT;
    wire sel_cnt  = PADDR_I == `OFF_COUNT_VALUE;
    wire sel_per  = PADDR_I == `OFF_PERIOD_LIMIT;
    wire sel_c0s  = PADDR_I == `OFF_CHAN0_CTL_STAT;
    wire sel_c0v  = PADDR_I == `OFF_CHAN0_COMPARE;
    wire sel_c1s  = PADDR_I == `OFF_CHAN1_CTL_STAT;
    wire sel_c1v  = PADDR_I == `OFF_CHAN1_COMPARE;
    wire sel_sys  = PADDR_I == `OFF_SYS_CTL;
    wire mapped   = sel_tcs | sel_cnt | sel_per | sel_c0s | sel_c0v | sel_c1s
                  | sel_c1v | sel_sys;

    // ************************************************************
    // Registers
    // ************************************************************
    logic             wrap_flag;
    logic             wrap_irq_en;
    logic             counter_halt;
    logic [2:0]       clock_divider_sel;
    logic [CNT_W-1:0] period_limit;
    logic [CNT_W-1:0] count;
    logic [6:0]       chan_cfg [2];
    logic [CNT_W-1:0] chan_compare [2];
    logic [1:0]       chan_event_flag;
    logic [1:0]       chan_flag_armed;
    logic             wrap_flag_armed;
    logic [3:0]       sys_ctl;
    buf_src_e         buf_src;
    buf_src_e         buf_last;
    logic [1:0]       pin_state;
    logic [5:0]       prescale;
    logic [1:0]       tclk_sync;
    logic             tclk_prev;

    // ************************************************************
    // Timer clock enable
    // ************************************************************
    wire in_wait    = sys_ctl[`SYS_WAIT];
    wire in_stop    = sys_ctl[`SYS_STOP];
    wire in_break   = sys_ctl[`SYS_BREAK];
    wire break_clr  = sys_ctl[`SYS_BREAK_CLR];
    wire clear_cnt  = wr & sel_tcs & PWDATA_I[`TCS_CLEAR_CNT];
    wire running    = ~counter_halt & ~in_stop & ~in_break;
    wire ext_sel    = clock_divider_sel == `DIV_EXT_CODE;
    wire ext_rise   = tclk_sync[1] & ~tclk_prev;
    wire [5:0] div_mask = 6'(7'h7F >> (3'h7 - clock_divider_sel)) & 6'h3F;
    wire int_tick   = (prescale & div_mask) == div_mask;
    wire tick       = running & (ext_sel ? ext_rise : int_tick);
    wire at_limit   = count == period_limit;
    wire [CNT_W-1:0] next_count = at_limit ? '0 : count + 1'b1;
    wire wrap       = tick & at_limit;

    // ************************************************************
    // Channel decode
    // ************************************************************
    function automatic logic [1:0] mode_of(input logic [6:0] c);
        mode_of = {c[`CCS_MODE_HI], c[`CCS_MODE_LO]};
    endfunction

    wire linked = mode_of(chan_cfg[0]) == `MODE_BUF;
    wire [CNT_W-1:0] eff_cmp0 = linked ? chan_compare[buf_src] : chan_compare[0];
    wire [1:0] chan_en;
    wire [1:0] chan_match;
    assign chan_en[0]    = mode_of(chan_cfg[0]) != 2'h0;
    assign chan_en[1]    = ~linked & (mode_of(chan_cfg[1]) != 2'h0);
    assign chan_match[0] = tick & chan_en[0] & (next_count == eff_cmp0);
    assign chan_match[1] = tick & chan_en[1] & (next_count == chan_compare[1]);

    // Flag clear: armed by a read seeing the flag, blocked in break unless allowed
    wire clr_ok   = ~in_break | break_clr;
    wire wr_tcs   = wr & sel_tcs;
    wire wrap_clr = wr_tcs & ~PWDATA_I[`TCS_WRAP_FLAG] & wrap_flag_armed & clr_ok;
    wire [1:0] ch_wr;
    assign ch_wr[0] = wr & sel_c0s;
    assign ch_wr[1] = wr & sel_c1s & ~linked;

    // ************************************************************
    // Timer control, counter, prescaler
    // ************************************************************
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            tclk_sync <= 2'h0;
            tclk_prev <= 1'b0;
        end else begin
            tclk_sync <= {tclk_sync[0], EXT_TCLK_I};
            tclk_prev <= tclk_sync[1];
        end
    end

    // Prescaler runs only while the counter may count
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            prescale <= 6'h00;
        end else if (clear_cnt) begin
            prescale <= 6'h00;
        end else if (running) begin
            prescale <= prescale + 6'h01;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            count <= '0;
        end else if (clear_cnt) begin
            count <= '0;
        end else if (tick) begin
            count <= next_count;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            counter_halt      <= 1'b1;
            wrap_irq_en       <= 1'b0;
            clock_divider_sel <= 3'h0;
        end else if (wr_tcs) begin
            counter_halt      <= PWDATA_I[`TCS_HALT];
            wrap_irq_en       <= PWDATA_I[`TCS_WRAP_IRQ_EN];
            clock_divider_sel <= PWDATA_I[`TCS_DIV_HI:`TCS_DIV_LO];
        end
    end

    // Period limit and system state inputs
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            period_limit <= `RST_PERIOD_LIMIT;
            sys_ctl      <= 4'h0;
        end else begin
            if (wr & sel_per) begin
                period_limit <= PWDATA_I[CNT_W-1:0];
            end
            if (wr & sel_sys) begin
                sys_ctl <= PWDATA_I[3:0];
            end
        end
    end

    // Overflow flag: set wins over clear
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            wrap_flag       <= 1'b0;
            wrap_flag_armed <= 1'b0;
        end else begin
            if (wrap) begin
                wrap_flag       <= 1'b1;
                wrap_flag_armed <= 1'b0;
            end else if (wrap_clr) begin
                wrap_flag       <= 1'b0;
                wrap_flag_armed <= 1'b0;
            end else if (rd & sel_tcs & wrap_flag & clr_ok) begin
                wrap_flag_armed <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Channels
    // ************************************************************
    for (genvar i = 0; i < 2; i++) begin : g_chan
        wire [1:0] act    = {chan_cfg[i][`CCS_ACT_HI], chan_cfg[i][`CCS_ACT_LO]};
        wire       tov    = chan_cfg[i][`CCS_TOGGLE_WRAP];
        wire       fmax   = chan_cfg[i][`CCS_FULL_DUTY];
        wire       w_tog  = wrap & tov;
        wire       forced = fmax & tov & act[1];
        wire       f_clr  = ch_wr[i] & ~PWDATA_I[`CCS_FLAG] & chan_flag_armed[i] & clr_ok;
        wire       c_wr   = wr & (i == 0 ? sel_c0v : sel_c1v);
        wire       c_rd   = rd & (i == 0 ? sel_c0s : sel_c1s);
        logic      next_pin;

        always_comb begin
            next_pin = pin_state[i];
            if (w_tog) begin
                next_pin = ~pin_state[i];
            end
            if (chan_match[i]) begin
                case (act)
                    `ACT_TOGGLE: next_pin = ~next_pin;
                    `ACT_CLEAR:  next_pin = 1'b0;
                    `ACT_SET:    next_pin = 1'b1;
                    default:     next_pin = next_pin;
                endcase
            end
            if (forced) begin
                next_pin = ~act[0];
            end
        end

        always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
            if (!ARST_N_I) begin
                chan_cfg[i]     <= 7'h00;
                chan_compare[i] <= '0;
                pin_state[i]    <= 1'b0;
            end else begin
                pin_state[i] <= next_pin;
                if (ch_wr[i]) begin
                    chan_cfg[i] <= PWDATA_I[6:0];
                end
                if (c_wr) begin
                    chan_compare[i] <= PWDATA_I[CNT_W-1:0];
                end
            end
        end

        // Channel flag with two-step clear; a new event wins
        always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
            if (!ARST_N_I) begin
                chan_event_flag[i] <= 1'b0;
                chan_flag_armed[i] <= 1'b0;
            end else if (chan_match[i]) begin
                chan_event_flag[i] <= 1'b1;
                chan_flag_armed[i] <= 1'b0;
            end else if (f_clr) begin
                chan_event_flag[i] <= 1'b0;
                chan_flag_armed[i] <= 1'b0;
            end else if (c_rd & chan_event_flag[i] & clr_ok) begin
                chan_flag_armed[i] <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Buffered pair selection
    // ************************************************************
    wire wr_c0v = wr & sel_c0v;
    wire wr_c1v = wr & sel_c1v;

    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            buf_src  <= SRC_CHAN0;
            buf_last <= SRC_CHAN0;
        end else begin
            if (!linked) begin
                buf_src  <= SRC_CHAN0;
                buf_last <= SRC_CHAN0;
            end else begin
                if (wr_c0v) begin
                    buf_last <= SRC_CHAN0;
                end else if (wr_c1v) begin
                    buf_last <= SRC_CHAN1;
                end
                if (wrap) begin
                    buf_src <= buf_last;
                end
            end
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    wire [7:0] tcs_rd = {wrap_flag, wrap_irq_en, counter_halt, 1'b0, 1'b0,
                         clock_divider_sel};
    wire [7:0] c0_rd  = {chan_event_flag[0], chan_cfg[0]};
    wire [7:0] c1_rd  = linked ? 8'h00 : {chan_event_flag[1], chan_cfg[1]};
    wire [31:0] rd_mux =
          sel_tcs ? {24'h0, tcs_rd}
        : sel_cnt ? 32'(count)
        : sel_per ? 32'(period_limit)
        : sel_c0s ? {24'h0, c0_rd}
        : sel_c0v ? 32'(chan_compare[0])
        : sel_c1s ? {24'h0, c1_rd}
        : sel_c1v ? 32'(chan_compare[1])
        : sel_sys ? {28'h0, sys_ctl}
        : 32'h0;

    // ************************************************************
    // Interrupt request levels
    // ************************************************************
    wire       wrap_irq_lvl = wrap_flag & wrap_irq_en;
    wire [1:0] chan_irq_lvl;
    assign chan_irq_lvl[0] = chan_event_flag[0] & chan_cfg[0][`CCS_IRQ_EN];
    assign chan_irq_lvl[1] = chan_event_flag[1] & chan_cfg[1][`CCS_IRQ_EN] & ~linked;

    // ************************************************************
    // Outputs
    // ************************************************************
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            PRDATA_O  <= 32'h0;
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
        end else begin
            PREADY_O  <= setup;
            PRDATA_O  <= rd_setup ? rd_mux : 32'h0;
            PSLVERR_O <= setup & ~mapped;
        end
    end

    // Pins and requests, one cycle behind the state
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            CHAN0_PIN_O    <= 1'b0;
            CHAN0_PIN_OE_O <= 1'b0;
            CHAN1_PIN_O    <= 1'b0;
            CHAN1_PIN_OE_O <= 1'b0;
            WRAP_IRQ_O     <= 1'b0;
            CHAN0_IRQ_O    <= 1'b0;
            CHAN1_IRQ_O    <= 1'b0;
        end else begin
            CHAN0_PIN_O    <= pin_state[0];
            CHAN0_PIN_OE_O <= chan_en[0];
            CHAN1_PIN_O    <= pin_state[1];
            CHAN1_PIN_OE_O <= chan_en[1];
            WRAP_IRQ_O     <= wrap_irq_lvl;
            CHAN0_IRQ_O    <= chan_irq_lvl[0];
            CHAN1_IRQ_O    <= chan_irq_lvl[1];
        end
    end

endmodule // timer_pwm_channel_pair

`default_nettype wire

// [shared/pwm_pair_map.svh]
// Register offsets, field positions and reset values of the PWM channel pair.
// Assumes inclusion by bare name from the testbench and the core module.
`ifndef PWM_PAIR_MAP_SVH
`define PWM_PAIR_MAP_SVH

// Byte addresses of the APB registers
`define OFF_TIMER_CTL_STAT  12'h000
`define OFF_COUNT_VALUE     12'h004
`define OFF_PERIOD_LIMIT    12'h008
`define OFF_CHAN0_CTL_STAT  12'h00C
`define OFF_CHAN0_COMPARE   12'h010
`define OFF_CHAN1_CTL_STAT  12'h014
`define OFF_CHAN1_COMPARE   12'h018
`define OFF_SYS_CTL         12'h01C

// Timer control and status fields
`define TCS_WRAP_FLAG       7
`define TCS_WRAP_IRQ_EN     6
`define TCS_HALT            5
`define TCS_CLEAR_CNT       4
`define TCS_DIV_HI          2
`define TCS_DIV_LO          0

// Channel control and status fields
`define CCS_FLAG            7
`define CCS_IRQ_EN          6
`define CCS_MODE_HI         5
`define CCS_MODE_LO         4
`define CCS_ACT_HI          3
`define CCS_ACT_LO          2
`define CCS_TOGGLE_WRAP     1
`define CCS_FULL_DUTY       0

// System control fields: wait, stop, break, break clear allow
`define SYS_WAIT            0
`define SYS_STOP            1
`define SYS_BREAK           2
`define SYS_BREAK_CLR       3

// Reset values and constants
`define RST_PERIOD_LIMIT    16'hFFFF
`define RST_TIMER_CTL       8'h20
`define DIV_EXT_CODE        3'h7
`define MODE_UNBUF          2'h1
`define MODE_BUF            2'h2
`define ACT_TOGGLE          2'h1
`define ACT_CLEAR           2'h2
`define ACT_SET             2'h3

`endif

// [shared/pwm_pair_pkg.sv]
// Types shared by the PWM channel pair.
// Assumes the map header is on the include path.
`default_nettype none

package pwm_pair_pkg;
    // Which compare register pair drives the linked output
    typedef enum logic [0:0] {
        SRC_CHAN0 = 1'b0,
        SRC_CHAN1 = 1'b1
    } buf_src_e;

    typedef logic [7:0] reg8_t;
endpackage

`default_nettype wire

// [verif/pwm_pair_assertions.sv]
// Concurrent checks on the APB side and the overflow interrupt output of the PWM pair.
// Assumes binding to the top module; one clock domain, async active-low reset.
`default_nettype none

module pwm_pair_assertions (
    // Clock and reset
    input wire logic        CLK_SYS_I,
    input wire logic        ARST_N_I,
    // APB
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic        PREADY_O,
    input wire logic        PSLVERR_O,
    // Interrupt
    input wire logic        WRAP_IRQ_O
);
    // ****************
    // Clocking
    // ****************
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!ARST_N_I);

    // ****************
    // Properties
    // ****************
    a_ready_after_setup: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
        else $error("ready missing after setup");
    a_ready_one_pulse: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready longer than one cycle");
    a_ready_in_access: assert property (PREADY_O |-> PSEL_I && PENABLE_I)
        else $error("ready outside access phase");
    a_err_with_ready: assert property (PSLVERR_O |-> PREADY_O)
        else $error("error without ready");
    a_rdata_idle_zero: assert property (!PREADY_O |-> PRDATA_O == 32'h0000_0000)
        else $error("read data not zero when idle");
    a_err_unmapped: assert property (PREADY_O && PADDR_I > 12'h01C |-> PSLVERR_O)
        else $error("unmapped access not refused");
    a_ok_mapped_addr: assert property
        (PREADY_O && PADDR_I <= 12'h01C && PADDR_I[1:0] == 2'b00 |-> !PSLVERR_O)
        else $error("mapped access refused");
    a_upper_read_zero: assert property (PREADY_O |-> PRDATA_O[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    a_clear_reads_zero: assert property
        (PREADY_O && !PWRITE_I && PADDR_I == 12'h000 |-> !PRDATA_O[4])
        else $error("counter clear bit reads one");
    a_irq_drop_write: assert property
        ($fell(WRAP_IRQ_O) |-> $past(PSEL_I && PENABLE_I && PWRITE_I, 2))
        else $error("wrap request dropped without write");
endmodule // pwm_pair_assertions

bind timer_pwm_channel_pair pwm_pair_assertions u_chk (
    .CLK_SYS_I  (CLK_SYS_I),
    .ARST_N_I   (ARST_N_I),
    .PSEL_I     (PSEL_I),
    .PENABLE_I  (PENABLE_I),
    .PWRITE_I   (PWRITE_I),
    .PADDR_I    (PADDR_I),
    .PRDATA_O   (PRDATA_O),
    .PREADY_O   (PREADY_O),
    .PSLVERR_O  (PSLVERR_O),
    .WRAP_IRQ_O (WRAP_IRQ_O)
);

`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for the PWM channel pair.
// Assumes the design, its map header and the checker are compiled first.
`default_nettype none
`include "pwm_pair_map.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk    = 1'b0;
    logic        rst_n  = 1'b0;
    logic        psel   = 1'b0;
    logic        pen    = 1'b0;
    logic        pwr    = 1'b0;
    logic [11:0] paddr  = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready, pslverr, p0, oe0, p1, oe1, irq_w, irq0, irq1;
    logic [32:0] exp_q[$];
    logic [32:0] exp_e;
    logic [31:0] rd;
    logic        rd_err;
    logic [31:0] rnd    = 32'h0000_003F;
    int          bad_count = 0;
    int          cmp_count = 0;

    always #2.5 clk = ~clk;

    timer_pwm_channel_pair u_dut (
        .CLK_SYS_I(clk), .ARST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .EXT_TCLK_I(1'b0),
        .CHAN0_PIN_O(p0), .CHAN0_PIN_OE_O(oe0), .CHAN1_PIN_O(p1),
        .CHAN1_PIN_OE_O(oe1), .WRAP_IRQ_O(irq_w), .CHAN0_IRQ_O(irq0),
        .CHAN1_IRQ_O(irq1)
    );

    // ****************
    // Checking
    // ****************
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    always @(posedge clk) begin
        if (pready === 1'b1 && exp_q.size() > 0) begin
            exp_e = exp_q.pop_front();
            if (exp_e[32]) begin
                chk(prdata, exp_e[31:0]);
            end
        end
    end

    // ****************
    // Drivers
    // ****************
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int n;
        @(posedge clk);
        exp_q.push_back(e);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 50) begin
            chk(32'(pready), 32'h1);
            conclude();
        end
        rd     = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask

    task automatic rdx(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b1, e});
    endtask

    task automatic meas(input int cyc, output int hi, output int rise);
        logic prev;
        prev = p0;
        hi   = 0;
        rise = 0;
        repeat (cyc) begin
            @(posedge clk);
            hi   += int'(p0);
            rise += int'(p0 && !prev);
            prev = p0;
        end
    endtask

    // ****************
    // Scenarios
    // ****************
    initial begin
        int hi1, hi2, hi, r, lim, per, c1;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rdx(`OFF_TIMER_CTL_STAT, 32'h0000_0020);
        rdx(`OFF_PERIOD_LIMIT, 32'h0000_FFFF);
        rdx(12'h040, 32'h0000_0000);
        chk(32'(rd_err), 32'h1);
        for (int s = 0; s < 5; s++) begin
            rnd = xs(rnd);
            lim = 3 + int'(rnd[1:0]);
            per = (lim + 1) << s;
            wr(`OFF_TIMER_CTL_STAT, 32'h0000_0030);
            wr(`OFF_PERIOD_LIMIT, 32'(lim));
            wr(`OFF_CHAN0_COMPARE, 32'h0000_0001);
            wr(`OFF_CHAN0_CTL_STAT, 32'h0000_005A);
            wr(`OFF_TIMER_CTL_STAT, 32'h0000_0040 | 32'(s));
            meas(8 * per + 2, hi, r);
            chk(32'(r), 32'h0000_0008);
        end
        wr(`OFF_PERIOD_LIMIT, 32'h0000_0007);
        wr(`OFF_TIMER_CTL_STAT, 32'h0000_0040);
        repeat (16) @(posedge clk);
        meas(80, hi1, r);
        chk(32'(hi1), 32'd10);
        wr(`OFF_CHAN0_COMPARE, 32'h0000_0003);
        repeat (16) @(posedge clk);
        meas(80, hi2, r);
        chk(32'(hi2 - hi1), 32'd20);
        wr(`OFF_CHAN0_CTL_STAT, 32'h0000_005E);
        repeat (16) @(posedge clk);
        meas(80, hi, r);
        chk(32'(hi), 32'(80 - hi2));
        wr(`OFF_CHAN0_CTL_STAT, 32'h0000_0058);
        repeat (16) @(posedge clk);
        meas(80, hi, r);
        chk(32'(hi), 32'h0);
        wr(`OFF_CHAN0_CTL_STAT, 32'h0000_005B);
        repeat (16) @(posedge clk);
        meas(80, hi, r);
        chk(32'(hi), 32'd80);
        rdx(`OFF_CHAN0_CTL_STAT, 32'h0000_00DB);
        chk(32'(irq0), 32'h1);
        wr(`OFF_TIMER_CTL_STAT, 32'h0000_0060);
        rdx(`OFF_TIMER_CTL_STAT, 32'h0000_00E0);
        chk(32'(irq_w), 32'h1);
        wr(`OFF_SYS_CTL, 32'h0000_0004);
        wr(`OFF_TIMER_CTL_STAT, 32'h0000_0060);
        rdx(`OFF_TIMER_CTL_STAT, 32'h0000_00E0);
        wr(`OFF_SYS_CTL, 32'h0000_0000);
        wr(`OFF_TIMER_CTL_STAT, 32'h0000_0060);
        rdx(`OFF_TIMER_CTL_STAT, 32'h0000_0060);
        wr(`OFF_PERIOD_LIMIT, 32'h0000_00FF);
        wr(`OFF_TIMER_CTL_STAT, 32'h0000_0000);
        for (int b = 0; b < 3; b++) begin
            wr(`OFF_SYS_CTL, 32'h1 << b);
            apb(1'b0, `OFF_COUNT_VALUE, 32'h0, 33'h0);
            c1 = int'(rd);
            repeat (20) @(posedge clk);
            apb(1'b0, `OFF_COUNT_VALUE, 32'h0, 33'h0);
            chk(32'(rd != 32'(c1)), 32'(b == 0));
        end
        wr(`OFF_SYS_CTL, 32'h0000_0000);
        wr(`OFF_TIMER_CTL_STAT, 32'h0000_0030);
        rdx(`OFF_COUNT_VALUE, 32'h0000_0000);
        wr(`OFF_PERIOD_LIMIT, 32'h0000_0007);
        wr(`OFF_CHAN0_COMPARE, 32'h0000_0001);
        wr(`OFF_CHAN1_CTL_STAT, 32'h0000_0010);
        wr(`OFF_CHAN0_CTL_STAT, 32'h0000_002A);
        rdx(`OFF_CHAN1_CTL_STAT, 32'h0000_0000);
        wr(`OFF_TIMER_CTL_STAT, 32'h0000_0000);
        repeat (16) @(posedge clk);
        meas(80, hi, r);
        chk(32'(hi), 32'(hi1));
        wr(`OFF_CHAN1_COMPARE, 32'h0000_0003);
        repeat (16) @(posedge clk);
        meas(80, hi, r);
        chk(32'(hi), 32'(hi2));
        chk(32'(oe1), 32'h0);
        chk(32'(oe0), 32'h1);
        wr(`OFF_CHAN0_COMPARE, 32'h0000_0001);
        repeat (16) @(posedge clk);
        meas(80, hi, r);
        chk(32'(hi), 32'(hi1));
        conclude();
    end
endmodule // testbench

`default_nettype wire
